// ---- hw/region_event_monitor.sv ----
// Purpose: per-region event flags and next-descriptor address of a monitor
// Assumes: events arrive as one-cycle beats synchronous to CLOCK_IN
// Notes:   flags are sticky; software clears them through FLAG_CLEAR_IN
`default_nettype none

// Behaviour
// - end flag set on end descriptor unless suppressed
// - wrap flag set on main wrap unless suppressed
// - bus error flag set on error unless suppressed
// - mismatch flag set on digest difference unless suppressed
// - hash done flag on zero next unless suppressed
// - end descriptor ends list, wrap bit ignored
// - next address is current plus 0x10, or base
module region_event_monitor
  import region_event_pkg::*;
(
  input  wire logic                               CLOCK_IN,           // system clock
  input  wire logic                               SYS_RST_IN,         // sync reset
  input  wire region_event_pkg::mon_event_t       EVENT_IN,           // event beat
  input  wire logic [region_event_pkg::ADDR_BITS-1:0] DESCRIPTOR_BASE_ADDRESS_IN, // list base
  input  wire logic                               MONITOR_START_IN,   // restart the list
  input  wire region_event_pkg::monitor_irq_status_t FLAG_CLEAR_IN,   // clear masks
  output var  region_event_pkg::monitor_irq_status_t MONITOR_IRQ_STATUS_OUT, // flags
  output var  logic [region_event_pkg::ADDR_BITS-1:0] NEXT_ADDR_OUT,  // next fetch address
  output var  logic                               NEXT_ADDR_VALID_OUT, // next address pulse
  output var  logic                               LIST_END_OUT        // list terminated
);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing state
  typedef struct packed {
    mon_state_t           mode;             // run or ended
    logic [ADDR_BITS-1:0] next_addr;        // next descriptor address
    logic                 next_valid;       // next address issued
  } seq_state_t;

  seq_state_t   state;                      // registered state
  seq_state_t   next_state;                 // next value
  logic [FLAG_KINDS-1:0] set_any;           // set condition per kind
  logic [FLAG_KINDS-1:0] suppress;          // suppress bit per kind
  flag_array_t  clear_arr;                  // clear masks as array
  flag_array_t  flag_arr;                   // flags as array

  ////////////////////////////////////////////////////////////////////////////
  // setting conditions per flag kind
  always_comb begin
    set_any  = '0;
    set_any[FLAG_END]      = EVENT_IN.desc_done && EVENT_IN.end_of_monitoring;
    set_any[FLAG_WRAP]     = EVENT_IN.desc_done && EVENT_IN.main_list
                             && EVENT_IN.wrap && !EVENT_IN.end_of_monitoring;
    set_any[FLAG_BUS_ERR]  = EVENT_IN.bus_error;
    set_any[FLAG_MISMATCH] = EVENT_IN.digest_mismatch;
    set_any[FLAG_HASH]     = EVENT_IN.desc_done && EVENT_IN.next_zero;
  end

  // suppress bits of the region config
  always_comb begin
    suppress                = '0;
    suppress[FLAG_END]      = EVENT_IN.cfg.end_irq_suppress;
    suppress[FLAG_WRAP]     = EVENT_IN.cfg.wrap_irq_suppress;
    suppress[FLAG_BUS_ERR]  = EVENT_IN.cfg.bus_error_irq_suppress;
    suppress[FLAG_MISMATCH] = EVENT_IN.cfg.digest_mismatch_irq_suppress;
    suppress[FLAG_HASH]     = EVENT_IN.cfg.hash_done_irq_suppress;
  end

  assign clear_arr = flag_array_t'(FLAG_CLEAR_IN);

  ////////////////////////////////////////////////////////////////////////////
  // one sticky bank per flag kind
  for (genvar k = 0; k < FLAG_KINDS; k++) begin : g_bank
    region_flag_bank u_bank (
      .clk_in      (CLOCK_IN),
      .rst_in      (SYS_RST_IN),
      .set_in      (set_any[k]),
      .suppress_in (suppress[k]),
      .region_in   (EVENT_IN.region),
      .clear_in    (clear_arr[k]),
      .flags_out   (flag_arr[k])
    );
  end

  assign MONITOR_IRQ_STATUS_OUT = monitor_irq_status_t'(flag_arr);

  ////////////////////////////////////////////////////////////////////////////
  // next descriptor address and list termination
  always_comb begin
    next_state            = state;
    next_state.next_valid = 1'b0;
    case (state.mode)
      MON_RUN: begin
        if (EVENT_IN.desc_done && EVENT_IN.main_list) begin
          if (EVENT_IN.end_of_monitoring) begin
            next_state.mode = MON_ENDED;                        // wrap ignored
          end else begin
            next_state.next_addr  = next_desc_addr(EVENT_IN.wrap, EVENT_IN.desc_addr,
                                                   DESCRIPTOR_BASE_ADDRESS_IN);
            next_state.next_valid = 1'b1;
          end
        end
      end
      MON_ENDED: begin
        // stays ended until software restarts
      end
      default: begin
        next_state.mode = MON_ENDED;
      end
    endcase
    if (MONITOR_START_IN) begin                                 // restart at the base
      next_state.mode       = MON_RUN;
      next_state.next_addr  = DESCRIPTOR_BASE_ADDRESS_IN;
      next_state.next_valid = 1'b1;
    end
  end

  // register the state
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      state.mode       <= MON_RUN;
      state.next_addr  <= NEXT_ADDR_RESET;
      state.next_valid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign NEXT_ADDR_OUT       = state.next_addr;
  assign NEXT_ADDR_VALID_OUT = state.next_valid;
  assign LIST_END_OUT        = (state.mode == MON_ENDED);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // every check runs on the system clock and rests while reset is high
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SYS_RST_IN);

  property p_end_set;
    EVENT_IN.desc_done && EVENT_IN.end_of_monitoring && !EVENT_IN.cfg.end_irq_suppress
      |=> MONITOR_IRQ_STATUS_OUT.region_end_flag[$past(EVENT_IN.region)];
  endproperty
  a_end_set: assert property (p_end_set) else $error("end flag not set");

  property p_end_suppressed;
    EVENT_IN.cfg.end_irq_suppress && EVENT_IN.desc_done
      && !MONITOR_IRQ_STATUS_OUT.region_end_flag[EVENT_IN.region]
      |=> !MONITOR_IRQ_STATUS_OUT.region_end_flag[$past(EVENT_IN.region)];
  endproperty
  a_end_suppressed: assert property (p_end_suppressed) else $error("suppressed end flag set");

  property p_wrap_set;
    EVENT_IN.desc_done && EVENT_IN.main_list && EVENT_IN.wrap
      && !EVENT_IN.end_of_monitoring && !EVENT_IN.cfg.wrap_irq_suppress
      |=> MONITOR_IRQ_STATUS_OUT.region_wrap_flag[$past(EVENT_IN.region)];
  endproperty
  a_wrap_set: assert property (p_wrap_set) else $error("wrap flag not set");

  property p_bus_err_set;
    EVENT_IN.bus_error && !EVENT_IN.cfg.bus_error_irq_suppress
      |=> MONITOR_IRQ_STATUS_OUT.region_bus_error_flag[$past(EVENT_IN.region)];
  endproperty
  a_bus_err_set: assert property (p_bus_err_set) else $error("bus error flag not set");

  property p_mismatch_set;
    EVENT_IN.digest_mismatch && !EVENT_IN.cfg.digest_mismatch_irq_suppress
      |=> MONITOR_IRQ_STATUS_OUT.region_digest_mismatch_flag[$past(EVENT_IN.region)];
  endproperty
  a_mismatch_set: assert property (p_mismatch_set) else $error("mismatch flag not set");

  property p_hash_set;
    EVENT_IN.desc_done && EVENT_IN.next_zero && !EVENT_IN.cfg.hash_done_irq_suppress
      |=> MONITOR_IRQ_STATUS_OUT.region_hash_done_flag[$past(EVENT_IN.region)];
  endproperty
  a_hash_set: assert property (p_hash_set) else $error("hash done flag not set");

  property p_eom_ends;
    !LIST_END_OUT && EVENT_IN.desc_done && EVENT_IN.main_list
      && EVENT_IN.end_of_monitoring && !MONITOR_START_IN
      |=> LIST_END_OUT && !NEXT_ADDR_VALID_OUT ##1 (LIST_END_OUT || $past(MONITOR_START_IN));
  endproperty
  a_eom_ends: assert property (p_eom_ends) else $error("end descriptor did not end list");

  // once ended, nothing is fetched until a restart
  property p_ended_quiet;
    LIST_END_OUT && !MONITOR_START_IN |=> LIST_END_OUT && !NEXT_ADDR_VALID_OUT;
  endproperty
  a_ended_quiet: assert property (p_ended_quiet) else $error("fetch after list end");

  // a restart fetches from the base address
  property p_start_base;
    MONITOR_START_IN |=> !LIST_END_OUT && NEXT_ADDR_VALID_OUT
      && NEXT_ADDR_OUT == $past(DESCRIPTOR_BASE_ADDRESS_IN);
  endproperty
  a_start_base: assert property (p_start_base) else $error("restart not from base");

  property p_next_stride;
    !LIST_END_OUT && EVENT_IN.desc_done && EVENT_IN.main_list && !EVENT_IN.wrap
      && !EVENT_IN.end_of_monitoring && !MONITOR_START_IN
      |=> NEXT_ADDR_VALID_OUT && NEXT_ADDR_OUT == $past(EVENT_IN.desc_addr) + DESC_STRIDE;
  endproperty
  a_next_stride: assert property (p_next_stride) else $error("next address not stride");

  property p_next_wrap;
    !LIST_END_OUT && EVENT_IN.desc_done && EVENT_IN.main_list && EVENT_IN.wrap
      && !EVENT_IN.end_of_monitoring
      |=> NEXT_ADDR_VALID_OUT && NEXT_ADDR_OUT == $past(DESCRIPTOR_BASE_ADDRESS_IN);
  endproperty
  a_next_wrap: assert property (p_next_wrap) else $error("wrap did not return to base");

  property p_other_regions;
    FLAG_CLEAR_IN == '0 ##0 1'b1
      |=> ((MONITOR_IRQ_STATUS_OUT.region_end_flag ^ $past(MONITOR_IRQ_STATUS_OUT.region_end_flag))
           & ~region_mask($past(EVENT_IN.region))) == '0;
  endproperty
  a_other_regions: assert property (p_other_regions) else $error("other region flag moved");

  c_end:      cover property (EVENT_IN.desc_done && EVENT_IN.end_of_monitoring ##1 LIST_END_OUT);
  c_wrap:     cover property (EVENT_IN.desc_done && EVENT_IN.wrap ##1 NEXT_ADDR_VALID_OUT);
  c_mismatch: cover property (EVENT_IN.digest_mismatch ##1
                              MONITOR_IRQ_STATUS_OUT.region_digest_mismatch_flag != '0);
  c_set_clr:  cover property (EVENT_IN.bus_error && FLAG_CLEAR_IN.region_bus_error_flag != '0);

endmodule : region_event_monitor

`default_nettype wire

// ---- hw/region_event_pkg.sv ----
// Purpose: shared types and constants for the region event flag logic
// Assumes: one clock, synchronous active-high reset
// Notes:   flags are held per region, one bit per region in each flag kind
`default_nettype none

package region_event_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes and constants
  localparam int unsigned REGION_COUNT = 4;            // regions watched
  localparam int unsigned REGION_BITS  = 2;            // width of a region index
  localparam int unsigned FLAG_KINDS   = 5;            // kinds of status flag
  localparam int unsigned ADDR_BITS    = 32;           // descriptor address width

  // flag kind positions inside the status array
  localparam int unsigned FLAG_END      = 0;           // end of monitoring
  localparam int unsigned FLAG_WRAP     = 1;           // wrap condition
  localparam int unsigned FLAG_BUS_ERR  = 2;           // system bus error
  localparam int unsigned FLAG_MISMATCH = 3;           // digest mismatch
  localparam int unsigned FLAG_HASH     = 4;           // region hash completed

  localparam logic [ADDR_BITS-1:0]    DESC_STRIDE      = 32'h0000_0010; // descriptor size
  localparam logic [ADDR_BITS-1:0]    NEXT_ADDR_RESET  = 32'h0000_0000; // next address at reset
  localparam logic [REGION_COUNT-1:0] FLAGS_RESET      = 4'h0;          // flags at reset

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef logic [REGION_COUNT-1:0] region_bits_t;      // one bit per region
  typedef logic [REGION_BITS-1:0]  region_idx_t;       // region index

  // per-descriptor configuration word, suppress bits active high
  typedef struct packed {
    logic end_irq_suppress;                            // keep end flag cleared
    logic wrap_irq_suppress;                           // keep wrap flag cleared
    logic bus_error_irq_suppress;                      // keep bus error flag cleared
    logic digest_mismatch_irq_suppress;                // keep mismatch flag cleared
    logic hash_done_irq_suppress;                      // keep hash done flag cleared
  } region_cfg_t;

  // one event beat from the descriptor engine
  typedef struct packed {
    logic                  desc_done;                  // descriptor processed pulse
    logic                  bus_error;                  // bus error pulse
    logic                  digest_mismatch;            // digest mismatch pulse
    region_idx_t           region;                     // region the beat belongs to
    logic                  main_list;                  // descriptor is in the main list
    logic                  end_of_monitoring;          // descriptor ends the main list
    logic                  wrap;                       // wrap command bit
    logic                  next_zero;                  // next field equals zero
    logic [ADDR_BITS-1:0]  desc_addr;                  // address of this descriptor
    region_cfg_t           cfg;                        // that region's configuration
  } mon_event_t;

  // software view of the flags
  typedef struct packed {
    region_bits_t region_hash_done_flag;               // hash completed per region
    region_bits_t region_digest_mismatch_flag;         // digest mismatch per region
    region_bits_t region_bus_error_flag;               // bus error per region
    region_bits_t region_wrap_flag;                    // wrap condition per region
    region_bits_t region_end_flag;                     // end of monitoring per region
  } monitor_irq_status_t;

  typedef logic [FLAG_KINDS-1:0][REGION_COUNT-1:0] flag_array_t; // same bits, indexable

  // monitoring sequence state
  typedef enum logic [0:0] {
    MON_RUN   = 1'b0,                                  // walking the list
    MON_ENDED = 1'b1                                   // list terminated
  } mon_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // one-hot mask of a region index
  function automatic region_bits_t region_mask(input region_idx_t idx);
    region_mask = region_bits_t'(1) << idx;
  endfunction : region_mask

  // address of the next descriptor to fetch
  function automatic logic [ADDR_BITS-1:0] next_desc_addr(
      input logic                 wrap,
      input logic [ADDR_BITS-1:0] cur,
      input logic [ADDR_BITS-1:0] base);
    next_desc_addr = wrap ? base : cur + DESC_STRIDE;
  endfunction : next_desc_addr

endpackage : region_event_pkg

`default_nettype wire

// ---- hw/region_flag_bank.sv ----
// Purpose: one kind of sticky status flag, one bit per region
// Assumes: set and clear are single-cycle pulses in the clock domain
// Notes:   a set in the same cycle as a clear of that bit wins
`default_nettype none

module region_flag_bank
  import region_event_pkg::*;
(
  input  wire logic         clk_in,        // system clock
  input  wire logic         rst_in,        // synchronous reset, active high
  input  wire logic         set_in,        // setting condition met
  input  wire logic         suppress_in,   // region config keeps flag cleared
  input  wire region_idx_t  region_in,     // region of the condition
  input  wire region_bits_t clear_in,      // software clear mask
  output var  region_bits_t flags_out      // current flags
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    region_bits_t flags;                   // sticky flags
  } bank_state_t;

  bank_state_t state;                      // registered state
  bank_state_t next_state;                 // next value

  // clear first, then set so the event is never lost
  always_comb begin
    next_state       = state;
    next_state.flags = state.flags & ~clear_in;
    if (set_in && !suppress_in) begin      // suppressed flags stay clear
      next_state.flags = next_state.flags | region_mask(region_in);
    end
  end

  // register the state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state.flags <= FLAGS_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign flags_out = state.flags;

endmodule : region_flag_bank

`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the region event monitor
// Assumes: inputs change at the falling edge; outputs are sampled there
// Notes:   expected flags live in a local flag array, built from the event kinds
`default_nettype none

module tb_top import region_event_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  //////////////////////////////////////////////////////////////////////////////
  // signals
  logic                  clk        = 1'b0;  // system clock
  logic                  rst        = 1'b1;  // sync reset
  mon_event_t            ev         = '0;    // event beat driven
  logic [ADDR_BITS-1:0]  base       = 32'h2000_0100; // list base
  logic                  start      = 1'b0;  // restart pulse
  monitor_irq_status_t   clr        = '0;    // clear masks
  monitor_irq_status_t   status;             // flags seen
  logic [ADDR_BITS-1:0]  next_addr;          // next fetch address seen
  logic                  next_valid;         // next address pulse seen
  logic                  list_end;           // list terminated seen
  flag_array_t           exp        = '0;    // expected flags
  int                    error_cnt  = 0;     // mismatches
  int                    checks     = 0;     // comparisons made
  // pulses {done, bus error, mismatch} and qualifiers {main, eom, wrap, next zero}
  logic [2:0]            pul [5]    = '{3'b100, 3'b100, 3'b010, 3'b001, 3'b100};
  logic [3:0]            knd [5]    = '{4'b0100, 4'b1010, 4'b0000, 4'b0000, 4'b0001};

  // 100 MHz clock
  always #5 clk = ~clk;

  region_event_monitor dut (
    .CLOCK_IN                   (clk),
    .SYS_RST_IN                 (rst),
    .EVENT_IN                   (ev),
    .DESCRIPTOR_BASE_ADDRESS_IN (base),
    .MONITOR_START_IN           (start),
    .FLAG_CLEAR_IN              (clr),
    .MONITOR_IRQ_STATUS_OUT     (status),
    .NEXT_ADDR_OUT              (next_addr),
    .NEXT_ADDR_VALID_OUT        (next_valid),
    .LIST_END_OUT               (list_end)
  );

  //////////////////////////////////////////////////////////////////////////////
  // compare tasks, one per kind of result
  task automatic cmp_bit(input string what, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %b, seen %b", what, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_word(input string what, input logic [ADDR_BITS-1:0] e,
                          input logic [ADDR_BITS-1:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : cmp_word

  task automatic cmp_flags(input string what);
    checks++;
    if (flag_array_t'(status) !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, flag_array_t'(status));
    end
  endtask : cmp_flags

  // build one event beat
  function automatic mon_event_t mk(input logic [2:0] p, input int r, input logic [3:0] q,
                                    input logic [ADDR_BITS-1:0] a, input region_cfg_t c);
    mon_event_t e;
    e                   = '0;
    {e.desc_done, e.bus_error, e.digest_mismatch} = p;
    {e.main_list, e.end_of_monitoring, e.wrap, e.next_zero} = q;
    e.region            = region_idx_t'(r);
    e.desc_addr         = a;
    e.cfg               = c;
    return e;
  endfunction : mk

  // present a beat for one edge; the caller lands on the next falling edge
  task automatic beat(input mon_event_t e);
    ev = e;
    @(negedge clk);
  endtask : beat

  // verdict and end of run
  task automatic close_out;
    $display("checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  //////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the 58 cycles of the tests
  initial begin : watchdog
    #50us;
    error_cnt++;
    close_out();
  end

  // main sequence
  initial begin : main_seq
    repeat (4) @(negedge clk);
    rst = 1'b0;
    cmp_flags("flags at reset");
    cmp_word("next addr at reset", 32'h0000_0000, next_addr);
    cmp_bit("valid at reset", 1'b0, next_valid);
    cmp_bit("list end at reset", 1'b0, list_end);
    // every flag kind, every region, suppressed first then allowed, back to back
    for (int k = 0; k < 5; k++) begin
      for (int r = 0; r < 4; r++) begin
        for (int s = 1; s >= 0; s--) begin
          beat(mk(pul[k], r, knd[k], 32'h0000_0040, region_cfg_t'(5'(s) << (4 - k))));
          if (s == 0) begin
            exp[k][r] = 1'b1;
          end
          cmp_flags("flags after beat");
        end
      end
      ev  = '0;
      clr = '1;
      @(negedge clk);
      clr = '0;
      exp = '0;
      cmp_flags("flags after clear");
    end
    // restart at the base address
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    cmp_bit("list end after start", 1'b0, list_end);
    cmp_bit("valid after start", 1'b1, next_valid);
    cmp_word("addr after start", base, next_addr);
    // plain step, then wrap, back to back
    beat(mk(3'b100, 1, 4'b1000, 32'h2000_0130, '0));
    cmp_bit("valid after step", 1'b1, next_valid);
    cmp_word("addr after step", 32'h2000_0140, next_addr);
    beat(mk(3'b100, 3, 4'b1010, 32'h2000_0140, '0));
    exp[FLAG_WRAP][3] = 1'b1;
    cmp_bit("valid after wrap", 1'b1, next_valid);
    cmp_word("addr after wrap", base, next_addr);
    cmp_flags("flags after wrap");
    // wrap bit outside the main list: no flag, no address
    beat(mk(3'b100, 0, 4'b0010, 32'h2000_0300, '0));
    cmp_bit("valid second list", 1'b0, next_valid);
    cmp_flags("flags second list");
    // end descriptor with wrap set: list ends, wrap ignored
    beat(mk(3'b100, 2, 4'b1110, 32'h2000_0150, '0));
    exp[FLAG_END][2] = 1'b1;
    cmp_flags("flags after end");
    cmp_bit("list end after end", 1'b1, list_end);
    cmp_bit("valid after end", 1'b0, next_valid);
    ev = '0;
    @(negedge clk);
    cmp_bit("list end holds", 1'b1, list_end);
    cmp_bit("valid idle", 1'b0, next_valid);
    // descriptor while ended: flags still set, no address issued
    beat(mk(3'b100, 1, 4'b1001, 32'h2000_0160, '0));
    exp[FLAG_HASH][1] = 1'b1;
    cmp_flags("flags while ended");
    cmp_bit("valid while ended", 1'b0, next_valid);
    cmp_bit("list end while ended", 1'b1, list_end);
    // set and clear of one bit in one cycle: set wins; other cleared bit drops
    clr.region_bus_error_flag = 4'h1;
    clr.region_hash_done_flag = 4'h2;
    beat(mk(3'b010, 0, 4'b0000, 32'h0000_0000, '0));
    clr = '0;
    exp[FLAG_BUS_ERR][0] = 1'b1;
    exp[FLAG_HASH][1]    = 1'b0;
    cmp_flags("flags set over clear");
    // restart in the same cycle as an end descriptor: restart wins
    start = 1'b1;
    beat(mk(3'b100, 0, 4'b1100, 32'h2000_0170, '0));
    start = 1'b0;
    exp[FLAG_END][0] = 1'b1;
    cmp_flags("flags start with end");
    cmp_bit("list end start with end", 1'b0, list_end);
    cmp_bit("valid start with end", 1'b1, next_valid);
    cmp_word("addr start with end", base, next_addr);
    close_out();
  end

endmodule : tb_top

`default_nettype wire
